// ===== logic/phy_basic_regs.sv
// module: basic control and status register bank of a 10/100 transceiver
//
// Notes on behaviour
// - control bit 15 starts soft reset, self-clears
// - other control writes ignored during soft reset
// - bit 14 sets loopback, reads back state
// - bit 13 forces speed when negotiation off
// - read returns software speed; aux shows combined
// - strap low or bit 12 zero disables negotiation
// - bit 12 writes ignored under strap disable
// - bit 11 powers down the channel
// - bit 10 isolates interface outputs and inputs
// - bit 9 restarts negotiation, reads zero
// - half duplex default; bit 8 forces full when negotiation off
// - collision test drives col from txen
// - status fixed ability bits
// - suppression needs two preamble bits, not 32
// - status bit 5 shows negotiation complete
// - status bit 4 latches far-end fault
// - link bit reads pass, latches low on fail
// - link bit returns high after read if passing
// - jabber only at 10 Mb; clears on read
`default_nettype none
module phy_basic_regs #(
    parameter int SRST_CYCLES = phy_regs_pkg::SRST_CYCLES,
    parameter int BIT_CYCLES  = 1
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic [4:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [15:0] regWdata,
    output logic      [15:0] regRdata,
    input  wire logic        negotiationStrapPin,
    input  wire logic        hwForce100,
    input  wire logic        anComplete,
    input  wire logic        remoteFault,
    input  wire logic        linkPass,
    input  wire logic        jabber,
    input  wire logic        txEn,
    output logic             col,
    output logic             softResetBusy,
    output logic             loopback,
    output logic             speed100,
    output logic             fullDuplex,
    output logic             anEnabled,
    output logic             anRestart,
    output logic             powerDown,
    output logic             isolate,
    output logic             preambleSuppress,
    output logic      [5:0]  preambleBits
);
    initial begin
        if (BIT_CYCLES < 1 || BIT_CYCLES > 64) $error("bit cycles out of range");
    end
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        return a == r;
    endfunction : hit
    logic wrCtrl, wrStat, rdStat, srBusy;
    soft_reset_if sr ();
    soft_reset_timer #(.CYCLES(SRST_CYCLES)) timerInst (
        .clk   (clk),
        .rst_n (rst_n),
        .clkEn (clkEn),
        .sr    (sr)
    );
    assign srBusy = sr.busy | sr.start;
    assign wrCtrl = clkEn & regWrite & hit(regAddr, phy_regs_pkg::CTRL_ADDR);
    assign wrStat = clkEn & regWrite & hit(regAddr, phy_regs_pkg::STAT_ADDR);
    assign rdStat = clkEn & regRead & hit(regAddr, phy_regs_pkg::STAT_ADDR);
    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic srStart_reg, loop_reg, spd_reg, anSw_reg, pdn_reg, iso_reg;
    logic rstan_reg, dpx_reg, colt_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            srStart_reg <= 1'b0;
        end else if (clkEn) begin
            srStart_reg <= wrCtrl & regWdata[phy_regs_pkg::CTRL_RESET_BIT] & ~srBusy;
        end
    end
    assign sr.start = srStart_reg;
    always_ff @(posedge clk) begin
        if (!rst_n || (clkEn && srStart_reg)) begin
            loop_reg <= 1'b0;
            spd_reg  <= 1'b0;
            anSw_reg <= 1'b1;
            pdn_reg  <= 1'b0;
            iso_reg  <= 1'b0;
            dpx_reg  <= 1'b0;
            colt_reg <= 1'b0;
        end else if (wrCtrl && !srBusy && !regWdata[phy_regs_pkg::CTRL_RESET_BIT]) begin
            loop_reg <= regWdata[phy_regs_pkg::CTRL_LOOP_BIT];
            spd_reg  <= regWdata[phy_regs_pkg::CTRL_SPEED_BIT];
            if (negotiationStrapPin) begin
                anSw_reg <= regWdata[phy_regs_pkg::CTRL_NEGOTIATION_STRAP_PIN_BIT];
            end
            pdn_reg  <= regWdata[phy_regs_pkg::CTRL_PDN_BIT];
            iso_reg  <= regWdata[phy_regs_pkg::CTRL_ISO_BIT];
            dpx_reg  <= regWdata[phy_regs_pkg::CTRL_DPX_BIT];
            colt_reg <= regWdata[phy_regs_pkg::CTRL_COLT_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rstan_reg <= 1'b0;
        end else if (clkEn) begin
            rstan_reg <= wrCtrl & ~srBusy & regWdata[phy_regs_pkg::CTRL_RSTAN_BIT]
                         & anSw_reg & negotiationStrapPin;
        end
    end
    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    logic pre_reg, rf_reg, link_reg, jab_reg, linkSeen_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_reg <= 1'b0;
        end else if (wrStat) begin
            pre_reg <= regWdata[phy_regs_pkg::STAT_PRE_BIT];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rf_reg <= 1'b0;
        end else if (clkEn) begin
            rf_reg <= remoteFault | (rf_reg & ~rdStat);
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            jab_reg <= 1'b0;
        end else if (clkEn) begin
            jab_reg <= (jabber & ~speed100) | (jab_reg & ~rdStat);
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_reg     <= 1'b0;
            linkSeen_reg <= 1'b0;
        end else if (clkEn) begin
            if (rdStat) begin
                link_reg     <= linkPass;
                linkSeen_reg <= linkPass;
            end else if (!linkPass) begin
                link_reg <= 1'b0;
            end else if (!linkSeen_reg) begin
                link_reg     <= 1'b1;
                linkSeen_reg <= 1'b1;
            end
        end
    end
    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [15:0] ctrlView, statView, auxView;
    always_comb begin
        ctrlView = 16'h0000;
        ctrlView[phy_regs_pkg::CTRL_RESET_BIT] = srBusy;
        ctrlView[phy_regs_pkg::CTRL_LOOP_BIT]  = loop_reg;
        ctrlView[phy_regs_pkg::CTRL_SPEED_BIT] = spd_reg;
        ctrlView[phy_regs_pkg::CTRL_NEGOTIATION_STRAP_PIN_BIT]  = anSw_reg;
        ctrlView[phy_regs_pkg::CTRL_PDN_BIT]   = pdn_reg;
        ctrlView[phy_regs_pkg::CTRL_ISO_BIT]   = iso_reg;
        ctrlView[phy_regs_pkg::CTRL_DPX_BIT]   = dpx_reg;
        ctrlView[phy_regs_pkg::CTRL_COLT_BIT]  = colt_reg;
        statView = phy_regs_pkg::STAT_FIXED;
        statView[phy_regs_pkg::STAT_PRE_BIT]  = pre_reg;
        statView[phy_regs_pkg::STAT_ANC_BIT]  = anComplete;
        statView[phy_regs_pkg::STAT_RF_BIT]   = rf_reg;
        statView[phy_regs_pkg::STAT_LINK_BIT] = link_reg;
        statView[phy_regs_pkg::STAT_JAB_BIT]  = jab_reg;
        auxView = 16'h0000;
        auxView[phy_regs_pkg::AUX_SPEED_BIT] = speed100;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 16'h0000;
        end else if (clkEn && regRead) begin
            case (regAddr)
                phy_regs_pkg::CTRL_ADDR: regRdata <= ctrlView;
                phy_regs_pkg::STAT_ADDR: regRdata <= statView;
                phy_regs_pkg::AUX_ADDR:  regRdata <= auxView;
                default:                 regRdata <= 16'h0000;
            endcase
        end
    end
    // ------------------------------------------------------------
    // mode outputs
    // ------------------------------------------------------------
    logic anOn;
    assign anOn = negotiationStrapPin & anSw_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            softResetBusy    <= 1'b0;
            loopback         <= 1'b0;
            speed100         <= 1'b0;
            fullDuplex       <= 1'b0;
            anEnabled        <= 1'b0;
            anRestart        <= 1'b0;
            powerDown        <= 1'b0;
            isolate          <= 1'b0;
            preambleSuppress <= 1'b0;
            preambleBits     <= 6'(phy_regs_pkg::PRE_LONG);
        end else if (clkEn) begin
            softResetBusy    <= srBusy;
            loopback         <= loop_reg;
            speed100         <= anOn ? hwForce100 : (spd_reg | hwForce100);
            fullDuplex       <= ~anOn & dpx_reg;
            anEnabled        <= anOn;
            anRestart        <= rstan_reg;
            powerDown        <= pdn_reg;
            isolate          <= iso_reg;
            preambleSuppress <= pre_reg;
            preambleBits     <= pre_reg ? 6'(phy_regs_pkg::PRE_SHORT)
                                        : 6'(phy_regs_pkg::PRE_LONG);
        end
    end
    // ------------------------------------------------------------
    // collision test
    // ------------------------------------------------------------
    // col follows txen quickly
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            col <= 1'b0;
        end else if (clkEn) begin
            col <= colt_reg & txEn;
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    soft_reset_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(srStart_reg) && clkEn |=> sr.busy)
        else $error("soft reset not busy after start");
    ctrl_write_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        wrCtrl && sr.busy |=> $stable(loop_reg) && $stable(iso_reg))
        else $error("control changed during soft reset");
    strap_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        wrCtrl && !negotiationStrapPin && !srStart_reg |=> $stable(anSw_reg))
        else $error("negotiation bit written under strap");
    restart_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        rstan_reg && clkEn |=> !rstan_reg)
        else $error("restart did not self clear");
    fixed_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(clkEn && regRead && regAddr == phy_regs_pkg::STAT_ADDR)
        |-> regRdata[15:11] == 5'h0f && regRdata[3] && regRdata[0])
        else $error("fixed status bits wrong");
    fault_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        remoteFault && clkEn |=> rf_reg)
        else $error("fault not latched");
    fault_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        rf_reg && !rdStat |=> rf_reg)
        else $error("fault cleared without read");
    link_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && !linkPass |=> !link_reg)
        else $error("link not latched low");
    jabber_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
        !jab_reg && speed100 && clkEn |=> !jab_reg)
        else $error("jabber set at 100 Mb");
    col_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && colt_reg && txEn |=> col)
        else $error("collision test col late");
endmodule : phy_basic_regs
`default_nettype wire

// ===== pkg/phy_regs_pkg.sv
// package: register map, field positions, reset values and timing for basic control/status
`default_nettype none
package phy_regs_pkg;
    localparam logic [4:0]  CTRL_ADDR      = 5'h00;
    localparam logic [4:0]  STAT_ADDR      = 5'h01;
    localparam logic [4:0]  AUX_ADDR       = 5'h18;
    localparam int          CTRL_RESET_BIT = 15;
    localparam int          CTRL_LOOP_BIT  = 14;
    localparam int          CTRL_SPEED_BIT = 13;
    localparam int          CTRL_NEGOTIATION_STRAP_PIN_BIT  = 12;
    localparam int          CTRL_PDN_BIT   = 11;
    localparam int          CTRL_ISO_BIT   = 10;
    localparam int          CTRL_RSTAN_BIT = 9;
    localparam int          CTRL_DPX_BIT   = 8;
    localparam int          CTRL_COLT_BIT  = 7;
    localparam int          STAT_PRE_BIT   = 6;
    localparam int          STAT_ANC_BIT   = 5;
    localparam int          STAT_RF_BIT    = 4;
    localparam int          STAT_LINK_BIT  = 2;
    localparam int          STAT_JAB_BIT   = 1;
    localparam int          AUX_SPEED_BIT  = 8;
    localparam logic [15:0] STAT_FIXED     = 16'h7809;
    localparam int          CLK_MHZ        = 250;
    localparam int          SRST_NS        = 1000;
    localparam int          SRST_CYCLES    = (SRST_NS * CLK_MHZ + 999) / 1000;
    localparam int          COLON_BITS     = 512;
    localparam int          COLOFF_BITS    = 4;
    localparam int          PRE_LONG       = 32;
    localparam int          PRE_SHORT      = 2;
endpackage : phy_regs_pkg
`default_nettype wire

// ===== pkg/soft_reset_if.sv
// interface: soft reset request and busy between control bank and its timer
`default_nettype none
interface soft_reset_if;
    logic start;
    logic busy;
    modport ctrl  (output start, input busy);
    modport timer (input start, output busy);
endinterface : soft_reset_if
`default_nettype wire

// ===== logic/soft_reset_timer.sv
// module: counts the soft reset duration after a start pulse
`default_nettype none
module soft_reset_timer #(
    parameter int CYCLES = phy_regs_pkg::SRST_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    soft_reset_if.timer     sr
);
    initial begin
        if (CYCLES < 1 || CYCLES > 65535) $error("soft reset cycles out of range");
    end
    logic [15:0] cnt_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 16'h0000;
        end else if (clkEn) begin
            if (sr.start) begin
                cnt_reg <= 16'(CYCLES);
            end else if (cnt_reg != 16'h0000) begin
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end
    end
    assign sr.busy = (cnt_reg != 16'h0000);
endmodule : soft_reset_timer
`default_nettype wire

// ===== tb/station_model.sv
// partner: station manager issuing register reads and writes
`default_nettype none
module station_model (
    input  wire logic        clk,
    output logic      [4:0]  regAddr,
    output logic             regWrite,
    output logic             regRead,
    output logic      [15:0] regWdata,
    input  wire logic [15:0] regRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regAddr  = 5'h00;
        regWrite = 1'b0;
        regRead  = 1'b0;
        regWdata = 16'h0000;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == phy_regs_pkg::CTRL_ADDR) v = d & 16'hff80;
        if (a == phy_regs_pkg::STAT_ADDR) v = d & 16'h0040;
        @(negedge clk);
        regAddr  = a;
        regWdata = v;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        regWdata = ~v;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask : rd
endmodule : station_model
`default_nettype wire

// ===== tb/testbench.sv
// testbench: self-checking bench for the basic control and status bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] C = phy_regs_pkg::CTRL_ADDR;
    localparam logic [4:0] S = phy_regs_pkg::STAT_ADDR;
    logic        clk = 1'b0, rst_n, clkEn, negotiationStrapPin, hwForce100, anComplete;
    logic        remoteFault, linkPass, jabber, txEn, regWrite, regRead, col, softResetBusy;
    logic        loopback, speed100, fullDuplex, anEnabled, anRestart, powerDown, isolate;
    logic        preambleSuppress, seen;
    logic [4:0]  regAddr;
    logic [5:0]  preambleBits;
    logic [15:0] regWdata, regRdata, d;
    int          failCount = 0;
    int          checked = 0;
    always #2 clk = ~clk;
    phy_basic_regs #(.SRST_CYCLES(8), .BIT_CYCLES(1)) u_phy_basic_regs (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .negotiationStrapPin(negotiationStrapPin), .hwForce100(hwForce100),
        .anComplete(anComplete), .remoteFault(remoteFault), .linkPass(linkPass),
        .jabber(jabber), .txEn(txEn), .col(col), .softResetBusy(softResetBusy),
        .loopback(loopback), .speed100(speed100), .fullDuplex(fullDuplex),
        .anEnabled(anEnabled), .anRestart(anRestart), .powerDown(powerDown),
        .isolate(isolate), .preambleSuppress(preambleSuppress), .preambleBits(preambleBits));
    station_model u_station_model (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));
    // ----------------------------------------
    // compare and wait helpers
    // ----------------------------------------
    task automatic end_sim();
        $display("counts: checked=%0d mismatches=%0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1
    task automatic rdChk(input logic [4:0] a, input logic [15:0] exp);
        u_station_model.rd(a, d);
        chk16(d, exp);
    endtask : rdChk
    task automatic waitLvl(ref logic s, input logic lvl, input int bound);
        int n;
        n = 0;
        while (s !== lvl && n < bound) begin
            @(negedge clk);
            n++;
        end
        chk1(s, lvl);
        if (s !== lvl) end_sim();
    endtask : waitLvl
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdChk(C, 16'h1000);
        rdChk(S, 16'h7809);
        chk1(anEnabled, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_fields();
        u_station_model.wr(C, 16'h6d80);
        rdChk(C, 16'h6d80);
        chk1(loopback, 1'b1);
        chk1(powerDown, 1'b1);
        chk1(isolate, 1'b1);
        chk1(fullDuplex, 1'b1);
        chk1(speed100, 1'b1);
        txEn = 1'b1;
        waitLvl(col, 1'b1, 512);
        txEn = 1'b0;
        waitLvl(col, 1'b0, 4);
        u_station_model.wr(C, 16'h1000);
        rdChk(C, 16'h1000);
        chk1(isolate, 1'b0);
        $display("test fields done");
    endtask : t_fields
    task automatic t_speed();
        u_station_model.wr(C, 16'h3100);
        chk1(speed100, 1'b0);
        chk1(fullDuplex, 1'b0);
        rdChk(C, 16'h3100);
        u_station_model.wr(C, 16'h0000);
        chk1(speed100, 1'b0);
        hwForce100 = 1'b1;
        u_station_model.rd(phy_regs_pkg::AUX_ADDR, d);
        chk1(d[8], 1'b1);
        rdChk(C, 16'h0000);
        hwForce100 = 1'b0;
        u_station_model.wr(C, 16'h1000);
        $display("test speed done");
    endtask : t_speed
    task automatic t_restart();
        u_station_model.wr(C, 16'h1200);
        waitLvl(anRestart, 1'b1, 8);
        rdChk(C, 16'h1000);
        u_station_model.wr(C, 16'h0000);
        u_station_model.wr(C, 16'h0200);
        seen = anRestart;
        repeat (8) begin
            @(negedge clk);
            if (anRestart === 1'b1) seen = 1'b1;
        end
        chk1(seen, 1'b0);
        u_station_model.wr(C, 16'h1000);
        $display("test restart done");
    endtask : t_restart
    task automatic t_strap();
        negotiationStrapPin = 1'b0;
        @(negedge clk);
        @(negedge clk);
        chk1(anEnabled, 1'b0);
        u_station_model.wr(C, 16'h0000);
        rdChk(C, 16'h1000);
        negotiationStrapPin = 1'b1;
        u_station_model.wr(C, 16'h0000);
        rdChk(C, 16'h0000);
        u_station_model.wr(C, 16'h1000);
        chk1(anEnabled, 1'b1);
        $display("test strap done");
    endtask : t_strap
    task automatic t_soft();
        u_station_model.wr(C, 16'h4000);
        u_station_model.wr(C, 16'h8000);
        waitLvl(softResetBusy, 1'b1, 4);
        u_station_model.wr(C, 16'h0100);
        rdChk(C, 16'h9000);
        waitLvl(softResetBusy, 1'b0, 16);
        rdChk(C, 16'h1000);
        $display("test soft reset done");
    endtask : t_soft
    task automatic t_freeze();
        clkEn = 1'b0;
        u_station_model.wr(C, 16'h4000);
        chk1(loopback, 1'b0);
        clkEn = 1'b1;
        rdChk(C, 16'h1000);
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_status();
        u_station_model.wr(S, 16'h0040);
        chk1(preambleSuppress, 1'b1);
        chk16({10'h000, preambleBits}, 16'h0002);
        anComplete = 1'b1;
        rdChk(S, 16'h7869);
        remoteFault = 1'b1;
        @(negedge clk);
        remoteFault = 1'b0;
        rdChk(S, 16'h7879);
        rdChk(S, 16'h7869);
        linkPass = 1'b1;
        @(negedge clk);
        rdChk(S, 16'h786d);
        linkPass = 1'b0;
        @(negedge clk);
        linkPass = 1'b1;
        @(negedge clk);
        rdChk(S, 16'h7869);
        rdChk(S, 16'h786d);
        u_station_model.wr(C, 16'h0000);
        jabber = 1'b1;
        @(negedge clk);
        jabber = 1'b0;
        rdChk(S, 16'h786f);
        rdChk(S, 16'h786d);
        u_station_model.wr(C, 16'h2000);
        jabber = 1'b1;
        @(negedge clk);
        jabber = 1'b0;
        rdChk(S, 16'h786d);
        u_station_model.wr(S, 16'h0000);
        chk16({10'h000, preambleBits}, 16'h0020);
        $display("test status done");
    endtask : t_status
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        negotiationStrapPin = 1'b1;
        {hwForce100, anComplete, remoteFault, linkPass, jabber, txEn} = 6'h00;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_fields();
        t_speed();
        t_restart();
        t_strap();
        t_soft();
        t_freeze();
        t_status();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
